// ### shared/tcc_pkg.sv
// constants, types and helpers of the timer channel capture/compare block
// Overview of operation
// - edge code 00: mode bit A one presets pin low, zero presets high
// - capture mode: code 01 rising, 10 falling, 11 either edge
// - unbuffered compare: match toggles (01), clears (10) or sets (11) pin
// - buffered compare: same match actions, mode bit A ignored
// - edge code 00 hands the pin to the port, no capture or compare
// - compare modes with overflow toggle invert the pin on overflow
// - overflow toggle wins over a coincident compare match
// - full-duty bit forces 100% level, applied from next PWM cycle
// - full duty affects only the pin; matches still set the flag
// - reset clears edge bits, overflow toggle and full duty everywhere
// - 16-bit value register: captured counter or compare match value
// - value registers keep no defined reset value
// - capture mode: high-byte read blocks captures until low-byte read
// - a capture before the high-byte read overwrites the old value
// - software writes replace the value, even unread captures
// - unbuffered: no matches between high-byte and low-byte writes
// - buffered: only writes to the active register block matches
// - unused value registers stay plain read/write storage
// - channel pins: direction bit under port only; capture in, compare out
// - pair buffered bit set: odd pin is a port pin by its direction bit
// - clock pin is counter clock only for prescaler select 111
// - flag sets on capture edge or on counter equal to value
// - buffered bit on even channel disables the odd control register
// - mode bit A counts only while the pair buffered bit is zero or the edge code is 00
package tcc_pkg;
  localparam int CHANNELS = 4;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] CTRL_BASE = 8'h00;
  localparam logic [7:0] VALUE_BASE = 8'h10;
  localparam logic [7:0] DIR_ADDR = 8'h30;
  localparam logic [7:0] PRESCALE_ADDR = 8'h34;
  localparam logic [7:0] WORD_STEP = 8'h04;
  localparam logic [7:0] CHAN_STEP = 8'h08;
  // control register fields
  localparam int BIT_FLAG = 7;
  localparam int BIT_IE = 6;
  localparam int BIT_MODEB = 5;
  localparam int BIT_MODEA = 4;
  localparam int BIT_ELSH = 3;
  localparam int BIT_ELSL = 2;
  localparam int BIT_TOV = 1;
  localparam int BIT_MAX = 0;
  localparam int BIT_CLKDIR = 4;
  // edge/level codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [2:0] PRESCALE_EXT = 3'h7;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // gray order along port, capture, unbuffered, buffered
  typedef enum logic [1:0] {
    MODE_PORT = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_UNBUF = 2'h3,
    MODE_BUF = 2'h2
  } tcc_mode_e;

  typedef struct packed {
    logic [3:0][7:0] ctrl;
    logic [3:0][15:0] value;
    logic [3:0] highWritten;
    logic [3:0] readLock;
    logic [3:0] flagArmed;
    logic [3:0] pinPrev;
    logic [3:0] level;
    logic [3:0] fullDuty;
    logic [1:0] activeOdd;
    logic [1:0] swapPending;
    logic [4:0] dir;
    logic [2:0] prescale;
    logic [31:0] rdata;
  } tcc_state_s;

  function automatic tcc_mode_e decodeMode(logic modeB, logic modeA, logic [1:0] els);
    if (els == EDGE_OFF) return MODE_PORT;
    if (modeB) return MODE_BUF;
    if (modeA) return MODE_UNBUF;
    return MODE_CAPTURE;
  endfunction : decodeMode

  function automatic logic [7:0] ctrlAddr(int ch);
    return CTRL_BASE + WORD_STEP * ch[7:0];
  endfunction : ctrlAddr

  function automatic logic [7:0] highAddr(int ch);
    return VALUE_BASE + CHAN_STEP * ch[7:0];
  endfunction : highAddr

  function automatic logic [7:0] lowAddr(int ch);
    return highAddr(ch) + WORD_STEP;
  endfunction : lowAddr

  // 100% duty level: high for toggle/clear PWM, low for set-on-match PWM
  function automatic logic fullDutyLevel(logic [1:0] els);
    return els != EDGE_BOTH;
  endfunction : fullDutyLevel
endpackage : tcc_pkg

// ### hdl/tcc_channel_event.sv
// per-channel capture edge and compare match detection
`timescale 1ns/100ps
module tcc_channel_event (
  input wire tcc_pkg::tcc_mode_e mode,
  input wire logic [1:0] els,
  input wire logic pinNow,
  input wire logic pinPrev,
  input wire logic counterStep,
  input wire logic [15:0] counterValue,
  input wire logic [15:0] compareValue,
  input wire logic inhibit,
  output logic captureHit,
  output logic matchHit
);
  logic rise;
  logic fall;
  logic isCompare;

  // edges seen between two bus clocks
  assign rise = pinNow & ~pinPrev;
  assign fall = ~pinNow & pinPrev;
  assign isCompare = (mode == tcc_pkg::MODE_UNBUF) | (mode == tcc_pkg::MODE_BUF);

  // active edge by code
  always_comb begin
    captureHit = 1'b0;
    if (mode == tcc_pkg::MODE_CAPTURE) begin
      case (els)
        tcc_pkg::EDGE_RISE: captureHit = rise;
        tcc_pkg::EDGE_FALL: captureHit = fall;
        tcc_pkg::EDGE_BOTH: captureHit = rise | fall;
        default: captureHit = 1'b0;
      endcase
    end
  end

  // match only when counter takes a new value, so a long equal stretch counts once
  assign matchHit = isCompare & counterStep & ~inhibit & (counterValue == compareValue);
endmodule : tcc_channel_event

// ### hdl/tcc_top.sv
// timer channel capture/compare unit with apb register slave
`timescale 1ns/100ps
module tcc_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] counterValue,
  input wire logic counterStep,
  input wire logic counterOverflow,
  input wire logic [3:0] channelPinIn,
  input wire logic [3:0] portDataOut,
  output logic [3:0] channelPinOut,
  output logic [3:0] channelPinOe,
  output logic [3:0] channelEventFlag,
  input wire logic clockPortData,
  output logic clockPinOut,
  output logic clockPinOe,
  output logic externalClockSelect
);
  tcc_pkg::tcc_state_s s_reg;
  tcc_pkg::tcc_state_s s_next;
  tcc_pkg::tcc_mode_e chMode [4];
  logic [3:0][1:0] chEls;
  logic [3:0][15:0] compareValue;
  logic [3:0] inhibit;
  logic [3:0] captureHit;
  logic [3:0] matchHit;
  logic [1:0] pairBuf;
  logic accessDone;
  logic writeDone;
  logic readDone;
  logic mapped;
  logic [31:0] readMux;

  // pair buffered bits live in the even control registers
  assign pairBuf[0] = s_reg.ctrl[0][tcc_pkg::BIT_MODEB];
  assign pairBuf[1] = s_reg.ctrl[2][tcc_pkg::BIT_MODEB];

  // effective mode per channel
  always_comb begin
    for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
      chEls[ch] = s_reg.ctrl[ch][tcc_pkg::BIT_ELSH:tcc_pkg::BIT_ELSL];
      if (ch % 2 == 0) begin
        chMode[ch] = tcc_pkg::decodeMode(pairBuf[ch / 2], s_reg.ctrl[ch][tcc_pkg::BIT_MODEA], chEls[ch]);
      end else if (pairBuf[ch / 2]) begin
        chMode[ch] = tcc_pkg::MODE_PORT;
      end else begin
        chMode[ch] = tcc_pkg::decodeMode(1'b0, s_reg.ctrl[ch][tcc_pkg::BIT_MODEA], chEls[ch]);
      end
    end
  end

  // compare source and write interlock; buffered pairs look at the active register only
  always_comb begin
    for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
      compareValue[ch] = s_reg.value[ch];
      inhibit[ch] = s_reg.highWritten[ch];
      if (ch % 2 == 0 && chMode[ch] == tcc_pkg::MODE_BUF) begin
        if (s_reg.activeOdd[ch / 2]) begin
          // ch | 1 names the odd partner and stays in range for every unrolled channel
          compareValue[ch] = s_reg.value[ch | 1];
          inhibit[ch] = s_reg.highWritten[ch | 1];
        end
      end
    end
  end

  // edge and match detection per channel
  for (genvar g = 0; g < tcc_pkg::CHANNELS; g++) begin : gen_chan
    tcc_channel_event u_event (
      .mode(chMode[g]),
      .els(chEls[g]),
      .pinNow(channelPinIn[g]),
      .pinPrev(s_reg.pinPrev[g]),
      .counterStep(counterStep),
      .counterValue(counterValue),
      .compareValue(compareValue[g]),
      .inhibit(inhibit[g]),
      .captureHit(captureHit[g]),
      .matchHit(matchHit[g])
    );
  end

  // apb phases; the slave never inserts wait states
  assign accessDone = psel & penable;
  assign writeDone = accessDone & pwrite;
  assign readDone = accessDone & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = accessDone & ~mapped;

  // read data selection and address map check
  always_comb begin
    readMux = '0;
    mapped = 1'b0;
    if (paddr == tcc_pkg::DIR_ADDR) begin
      mapped = 1'b1;
      readMux[4:0] = s_reg.dir;
    end
    if (paddr == tcc_pkg::PRESCALE_ADDR) begin
      mapped = 1'b1;
      readMux[2:0] = s_reg.prescale;
    end
    for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
      if (paddr == tcc_pkg::ctrlAddr(ch)) begin
        mapped = 1'b1;
        // a disabled odd control register reads as zero
        if (!(ch % 2 == 1 && pairBuf[ch / 2])) begin
          readMux[7:0] = s_reg.ctrl[ch];
        end
      end
      if (paddr == tcc_pkg::highAddr(ch)) begin
        mapped = 1'b1;
        readMux[7:0] = s_reg.value[ch][15:8];
      end
      if (paddr == tcc_pkg::lowAddr(ch)) begin
        mapped = 1'b1;
        readMux[7:0] = s_reg.value[ch][7:0];
      end
    end
  end

  // next state of the whole block
  always_comb begin
    s_next = s_reg;
    s_next.pinPrev = channelPinIn;
    // read data is sampled in the setup cycle so prdata comes from a flop
    if (psel & ~penable) begin
      s_next.rdata = readMux;
    end

    for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
      // capture latches the counter unless a high-byte read holds it
      if (captureHit[ch] & ~s_reg.readLock[ch]) begin
        s_next.value[ch] = counterValue;
      end

      // register reads with side effects
      if (readDone && paddr == tcc_pkg::ctrlAddr(ch) && s_reg.ctrl[ch][tcc_pkg::BIT_FLAG]) begin
        s_next.flagArmed[ch] = 1'b1;
      end
      if (readDone && paddr == tcc_pkg::highAddr(ch) && chMode[ch] == tcc_pkg::MODE_CAPTURE) begin
        s_next.readLock[ch] = 1'b1;
      end
      if (readDone && paddr == tcc_pkg::lowAddr(ch)) begin
        s_next.readLock[ch] = 1'b0;
      end

      // control write; flag only clears by writing zero after reading it set
      if (writeDone && paddr == tcc_pkg::ctrlAddr(ch)) begin
        if (!(ch % 2 == 1 && pairBuf[ch / 2])) begin
          s_next.ctrl[ch][6:0] = pwdata[6:0];
          if (ch % 2 == 1) begin
            s_next.ctrl[ch][tcc_pkg::BIT_MODEB] = 1'b0;
          end
          if (s_reg.flagArmed[ch] & ~pwdata[tcc_pkg::BIT_FLAG]) begin
            s_next.ctrl[ch][tcc_pkg::BIT_FLAG] = 1'b0;
          end
          s_next.flagArmed[ch] = 1'b0;
        end
      end

      // value writes win over a capture in the same cycle
      if (writeDone && paddr == tcc_pkg::highAddr(ch)) begin
        s_next.value[ch][15:8] = pwdata[7:0];
        s_next.highWritten[ch] = 1'b1;
      end
      if (writeDone && paddr == tcc_pkg::lowAddr(ch)) begin
        s_next.value[ch][7:0] = pwdata[7:0];
        s_next.highWritten[ch] = 1'b0;
      end

      // hardware set wins over a software clear in the same cycle
      if (captureHit[ch] | matchHit[ch]) begin
        s_next.ctrl[ch][tcc_pkg::BIT_FLAG] = 1'b1;
        // a new event voids a pending clear, so no event is lost to a stale read
        s_next.flagArmed[ch] = 1'b0;
      end

      // pin level: preset, overflow toggle, match action
      if (chEls[ch] == tcc_pkg::EDGE_OFF) begin
        s_next.level[ch] = ~s_reg.ctrl[ch][tcc_pkg::BIT_MODEA];
      end else if (chMode[ch] == tcc_pkg::MODE_UNBUF || chMode[ch] == tcc_pkg::MODE_BUF) begin
        if (counterOverflow & s_reg.ctrl[ch][tcc_pkg::BIT_TOV]) begin
          s_next.level[ch] = ~s_reg.level[ch];
        end else if (matchHit[ch]) begin
          case (chEls[ch])
            tcc_pkg::EDGE_RISE: s_next.level[ch] = ~s_reg.level[ch];
            tcc_pkg::EDGE_FALL: s_next.level[ch] = 1'b0;
            tcc_pkg::EDGE_BOTH: s_next.level[ch] = 1'b1;
            default: s_next.level[ch] = s_reg.level[ch];
          endcase
        end
      end

      // full duty is taken over only at a cycle boundary, so a change never cuts a pulse
      if (chMode[ch] != tcc_pkg::MODE_UNBUF && chMode[ch] != tcc_pkg::MODE_BUF) begin
        s_next.fullDuty[ch] = 1'b0;
      end else if (counterOverflow) begin
        s_next.fullDuty[ch] = s_reg.ctrl[ch][tcc_pkg::BIT_MAX];
      end
    end

    // buffered pairs: a completed write to the idle register swaps at next overflow
    for (int p = 0; p < tcc_pkg::CHANNELS / 2; p++) begin
      if (!pairBuf[p]) begin
        s_next.activeOdd[p] = 1'b0;
        s_next.swapPending[p] = 1'b0;
      end else begin
        if (counterOverflow & s_reg.swapPending[p]) begin
          s_next.activeOdd[p] = ~s_reg.activeOdd[p];
          s_next.swapPending[p] = 1'b0;
        end
        if (writeDone && paddr == tcc_pkg::lowAddr(2 * p + (s_reg.activeOdd[p] ? 0 : 1))) begin
          s_next.swapPending[p] = 1'b1;
        end
      end
    end

    // loose configuration registers
    if (writeDone && paddr == tcc_pkg::DIR_ADDR) begin
      s_next.dir = pwdata[4:0];
    end
    if (writeDone && paddr == tcc_pkg::PRESCALE_ADDR) begin
      s_next.prescale = pwdata[2:0];
    end

    // synchronous reset clears control state but leaves the value registers alone
    if (rst) begin
      s_next = '0;
      s_next.value = s_reg.value;
      for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
        s_next.ctrl[ch] = tcc_pkg::CTRL_RESET;
        s_next.level[ch] = 1'b1;
      end
      s_next.pinPrev = '0;
    end
  end

  // single state register
  always_ff @(posedge clock) begin
    s_reg <= s_next;
  end

  // pin drive per channel
  always_comb begin
    for (int ch = 0; ch < tcc_pkg::CHANNELS; ch++) begin
      case (chMode[ch])
        tcc_pkg::MODE_PORT: begin
          channelPinOe[ch] = s_reg.dir[ch];
          channelPinOut[ch] = portDataOut[ch];
        end
        tcc_pkg::MODE_CAPTURE: begin
          channelPinOe[ch] = 1'b0;
          channelPinOut[ch] = 1'b0;
        end
        tcc_pkg::MODE_UNBUF, tcc_pkg::MODE_BUF: begin
          channelPinOe[ch] = 1'b1;
          channelPinOut[ch] = s_reg.fullDuty[ch] ? tcc_pkg::fullDutyLevel(chEls[ch]) : s_reg.level[ch];
        end
        default: begin
          channelPinOe[ch] = 1'b0;
          channelPinOut[ch] = 1'b0;
        end
      endcase
      channelEventFlag[ch] = s_reg.ctrl[ch][tcc_pkg::BIT_FLAG];
    end
  end

  // external clock pin: counter clock only for the top prescaler code
  assign externalClockSelect = s_reg.prescale == tcc_pkg::PRESCALE_EXT;
  assign clockPinOe = ~externalClockSelect & s_reg.dir[tcc_pkg::BIT_CLKDIR];
  assign clockPinOut = clockPortData;
  assign prdata = s_reg.rdata;
endmodule : tcc_top

// ### bench/tcc_assertions.sv
// port checker for the capture/compare unit
`timescale 1ns/100ps
module tcc_assertions (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic counterStep,
  input wire logic [3:0] channelPinIn,
  input wire logic [3:0] portDataOut,
  input wire logic [3:0] channelPinOut,
  input wire logic [3:0] channelPinOe,
  input wire logic [3:0] channelEventFlag,
  input wire logic clockPortData,
  input wire logic clockPinOut,
  input wire logic clockPinOe,
  input wire logic externalClockSelect
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ready_always_a: assert property (pready) else $error("pready low");
  err_in_access_a: assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
  ext_clock_in_a: assert property (externalClockSelect |-> !clockPinOe)
    else $error("clock pin driven while counter clock");
  clock_port_a: assert property (clockPinOut == clockPortData)
    else $error("clock pin data wrong");
  read_width_a: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  reset_clears_a: assert property ($fell(rst) |-> channelEventFlag == 4'h0 && channelPinOe == 4'h0)
    else $error("state not cleared by reset");
  flag_cause_a: assert property ($rose(channelEventFlag[0]) |->
    $past(counterStep) || $past(channelPinIn[0]) != $past(channelPinIn[0], 2)) else $error("flag without event");
  pin_cause_a: assert property (channelPinOe[2] && $past(channelPinOe[2]) && $stable(portDataOut[2])
    && $changed(channelPinOut[2]) |-> $past(counterStep) || $past(psel && penable && pwrite))
    else $error("pin moved without cause");
  cover property ($rose(channelEventFlag[0]));
  cover property (pslverr);
  cover property (externalClockSelect);
endmodule : tcc_assertions

bind tcc_top tcc_assertions u_chk (.clock, .rst, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
  .counterStep, .channelPinIn, .portDataOut, .channelPinOut, .channelPinOe, .channelEventFlag,
  .clockPortData, .clockPinOut, .clockPinOe, .externalClockSelect);

// ### bench/tcc_partner.sv
// far-side model: shared counter and outside pin drivers
`timescale 1ns/100ps
module tcc_partner #(
  parameter logic [15:0] MOD = 16'h003F
) (
  input wire logic clock,
  input wire logic run,
  input wire logic slow,
  input wire logic ld,
  input wire logic [15:0] ldv,
  input wire logic [3:0] pinLevel,
  input wire logic [3:0] pinOut,
  input wire logic [3:0] pinOe,
  output logic [15:0] counterValue,
  output logic counterStep,
  output logic counterOverflow,
  output logic [3:0] channelPinIn
);
  logic ph;
  initial begin
    ph = 1'b0;
    counterValue = 16'h0000;
    counterStep = 1'b0;
    counterOverflow = 1'b0;
  end
  // counter steps every cycle, or every second one when slow
  always @(posedge clock) begin
    counterStep <= 1'b0;
    counterOverflow <= 1'b0;
    ph <= ~ph;
    if (ld) begin
      counterValue <= ldv;
      ph <= 1'b0;
    end else if (run && (!slow || ph)) begin
      counterValue <= (counterValue == MOD) ? 16'h0000 : counterValue + 16'h0001;
      counterStep <= 1'b1;
      counterOverflow <= counterValue == MOD; // wrap pulse rides on a step
    end
  end
  // chip wins the wire while it drives, else the outside driver
  assign channelPinIn = (pinOe & pinOut) | (~pinOe & pinLevel);
endmodule : tcc_partner

// ### bench/tcc_top_tb.sv
// self-checking bench for the capture/compare unit
`timescale 1ns/100ps
module tcc_top_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ld = 1'b0, run = 1'b0, slow = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, counterStep, counterOverflow, clockPinOut, clockPinOe, externalClockSelect;
  logic [15:0] counterValue, ldv = 16'h0000;
  logic [3:0] channelPinIn, channelPinOut, channelPinOe, channelEventFlag;
  logic [3:0] portDataOut = 4'h4, pinLevel = 4'h0;
  logic clockPortData = 1'b0;
  int badCount = 0, checksDone = 0, cycles = 0;

  always #2 clock = ~clock;
  tcc_top u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .counterValue, .counterStep, .counterOverflow, .channelPinIn, .portDataOut, .channelPinOut,
    .channelPinOe, .channelEventFlag, .clockPortData, .clockPinOut, .clockPinOe, .externalClockSelect);
  tcc_partner u_far (.clock, .run, .slow, .ld, .ldv, .pinLevel, .pinOut(channelPinOut),
    .pinOe(channelPinOe), .counterValue, .counterStep, .counterOverflow, .channelPinIn);

  task automatic giveVerdict;
    $display("checks %0d errors %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : giveVerdict
  // a hang counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      giveVerdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [7:0] ca(input int n);
    return tcc_pkg::CTRL_BASE + 8'(4 * n);
  endfunction : ca
  function automatic logic [7:0] va(input int n);
    return tcc_pkg::VALUE_BASE + 8'(8 * n);
  endfunction : va
  // one apb transfer; request held until pready is seen high, only the bench timeout ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(q, x);
  endtask : rd
  // load the counter, then let it run n cycles
  task automatic steps(input logic [15:0] v, input int n);
    ld <= 1'b1;
    ldv <= v;
    @(posedge clock) ld <= 1'b0;
    if (n > 0) run <= 1'b1;
    repeat (n) @(posedge clock);
    run <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : steps
  // rise with counter a, fall with counter b; loads kept away from the edges
  task automatic pulse(input logic [15:0] a, input logic [15:0] b);
    steps(a, 0);
    pinLevel[0] <= 1'b1;
    repeat (3) @(posedge clock);
    steps(b, 0);
    pinLevel[0] <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : pulse

  // main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) rd(ca(i), 32'h0);
    xfer(1'b0, 8'h3C, 32'h0);
    chk(e, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(va(i), 32'hA0 + 32'(i));
      wr(va(i) + 8'h04, 32'h50 + 32'(i));
      rd(va(i), 32'hA0 + 32'(i));
      rd(va(i) + 8'h04, 32'h50 + 32'(i));
    end
    // capture codes, pin held low long before each enable
    for (int c = 1; c < 4; c++) begin
      wr(ca(0), 32'(c << 2));
      pulse(16'h1200 + 16'(c), 16'h3400 + 16'(c));
      rd(ca(0), 32'h80 | 32'(c << 2));
      rd(va(0), c == 1 ? 32'h12 : 32'h34);
      rd(va(0) + 8'h04, 32'(c));
    end
    wr(ca(0), 32'h04);
    pulse(16'h1111, 16'h1111);
    pulse(16'h2222, 16'h2222);
    rd(va(0), 32'h22);
    pulse(16'h3333, 16'h3333);
    rd(va(0) + 8'h04, 32'h22);
    pulse(16'h4444, 16'h4444);
    rd(va(0), 32'h44);
    wr(va(0), 32'h9A);
    wr(va(0) + 8'h04, 32'hBC);
    rd(va(0) + 8'h04, 32'hBC);
    // unbuffered compare: toggle from low, clear from high, set from low
    for (int c = 1; c < 4; c++) begin
      wr(ca(2), c == 2 ? 32'h00 : 32'h10);
      wr(ca(2), 32'h10 | 32'(c << 2));
      chk(channelPinOut[2], c == 2);
      chk(channelPinOe[2], 1'b1);
      wr(va(2), 32'h0);
      wr(va(2) + 8'h04, 32'h05);
      steps(16'h0000, 8);
      chk(channelPinOut[2], c != 2);
    end
    wr(ca(2), 32'h14);
    wr(va(2), 32'h0);
    steps(16'h0000, 8);
    chk(channelPinOut[2], 1'b1);
    wr(va(2) + 8'h04, 32'h05);
    steps(16'h0000, 8);
    chk(channelPinOut[2], 1'b0);
    // set-on-match at the wrap with overflow toggle; slow counter
    wr(ca(2), 32'h00);
    wr(ca(2), 32'h1E);
    wr(va(2) + 8'h04, 32'h00);
    slow <= 1'b1;
    steps(16'h003E, 6);
    slow <= 1'b0;
    chk(channelPinOut[2], 1'b0);
    xfer(1'b0, ca(2), 32'h0);
    wr(ca(2), 32'h10);
    // clear-on-match keeps the level low, so only full duty can show a high pin
    wr(ca(2), 32'h19);
    wr(va(2) + 8'h04, 32'h05);
    steps(16'h0001, 2);
    chk(channelPinOut[2], 1'b0);
    steps(16'h003E, 10);
    chk(channelPinOut[2], 1'b1);
    rd(ca(2), 32'h99);
    wr(ca(2), 32'h00);
    wr(tcc_pkg::DIR_ADDR, 32'h04);
    chk(channelPinOut[2], portDataOut[2]);
    chk(channelPinOe, 4'h4);
    // buffered pair on channels 0 and 1
    wr(ca(0), 32'h10);
    wr(ca(0), 32'h24);
    wr(ca(1), 32'h14);
    rd(ca(1), 32'h0);
    wr(tcc_pkg::DIR_ADDR, 32'h02);
    chk(channelPinOe, 4'h3);
    wr(va(0), 32'h0);
    wr(va(0) + 8'h04, 32'h05);
    steps(16'h0000, 8);
    chk(channelPinOut[0], 1'b1);
    wr(va(1), 32'h0);
    steps(16'h0000, 8);
    chk(channelPinOut[0], 1'b0);
    // clock pin
    wr(tcc_pkg::PRESCALE_ADDR, 32'h07);
    wr(tcc_pkg::DIR_ADDR, 32'h10);
    chk(externalClockSelect, 1'b1);
    chk(clockPinOe, 1'b0);
    wr(tcc_pkg::PRESCALE_ADDR, 32'h06);
    clockPortData <= 1'b1;
    @(posedge clock);
    chk({clockPinOe, clockPinOut, externalClockSelect}, 3'h6);
    giveVerdict();
  end
endmodule : tcc_top_tb
